//--- src/dpm_pkg.sv
package dpm_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int SEM_SEL_W = 3;
  localparam logic [11:0] LEFT_MBOX_ADDR = 12'hFFE;
  localparam logic [11:0] RIGHT_MBOX_ADDR = 12'hFFF;
  localparam logic [15:0] SEM_TAKE_DATA = 16'h0000;
  localparam logic [15:0] SEM_FREE_DATA = 16'hFFFF;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int ACCESS_NS = 20;
  localparam int ACCESS_CYC = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TMR_W = 8;
  localparam int NUM_DEV = 1;

  typedef enum logic [2:0] {
    DPM_MEM_RD,
    DPM_MEM_WR,
    DPM_SEM_REQ,
    DPM_SEM_REL,
    DPM_SEM_RD,
    DPM_POST_MAIL,
    DPM_TAKE_MAIL
  } dpm_cmd_e;

  typedef enum logic [2:0] {
    DPM_ST_INIT,
    DPM_ST_IDLE,
    DPM_ST_SETUP,
    DPM_ST_STROBE,
    DPM_ST_WAITB,
    DPM_ST_END
  } dpm_state_e;
endpackage : dpm_pkg

//--- src/dpm_tmr_if.sv
`timescale 1ns/1ps
interface dpm_tmr_if;
  logic start;
  logic [7:0] load;
  logic done;
  modport ctrl (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface : dpm_tmr_if

//--- src/dpm_timer.sv
`timescale 1ns/1ps
module dpm_timer
  import dpm_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  dpm_tmr_if.tmr tif
);
  typedef struct packed {
    logic [TMR_W-1:0] cnt;
  } dpm_tmr_s;

  dpm_tmr_s s_r;
  dpm_tmr_s s_nxt;

  // Done is read one cycle after start, so a load of one or more is always seen
  assign tif.done = (s_r.cnt == '0);

  always_comb begin
    s_nxt = s_r;
    if (tif.start) begin
      s_nxt.cnt = tif.load;
    end else if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '0;
    end else if (i_clk_en) begin
      s_r <= s_nxt;
    end
  end
endmodule : dpm_timer

//--- src/dpm_host.sv
// Overview of operation
// - Without mailboxes, words FFE and FFF serve as plain memory.
// - Processors put both mailbox flags in a known state after power-up.
// - In slave role the system holds busy high, or low to block writes.
// - A low busy may stall the requester until the other side finishes.
// - Stacked devices combine busy outputs through an AND function.
// - Semaphore access holds memory select high and semaphore select low.
`timescale 1ns/1ps
module dpm_host
  import dpm_pkg::*;
#(
  parameter logic [11:0] OWN_MBOX = LEFT_MBOX_ADDR,
  parameter logic [11:0] PEER_MBOX = RIGHT_MBOX_ADDR,
  parameter int NDEV = NUM_DEV
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_cmd_valid,
  input wire dpm_cmd_e i_cmd,
  input wire logic [ADDR_W-1:0] i_cmd_addr,
  input wire logic [DATA_W-1:0] i_cmd_wdata,
  input wire logic i_block_writes,
  output logic o_cmd_ready,
  output logic o_rsp_valid,
  output logic [DATA_W-1:0] o_rsp_rdata,
  output logic o_rsp_stalled,
  output logic o_init_done,
  output logic o_mail_pending,
  output logic [ADDR_W-1:0] o_addr,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_rw_n,
  output logic o_token_space_select_n,
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oe_n,
  input wire logic [DATA_W-1:0] i_data,
  input wire logic [NDEV-1:0] i_contention_flag_n,
  input wire logic i_mailbox_flag_n,
  output logic o_contention_hold_n
);
  typedef struct packed {
    dpm_state_e st;
    dpm_cmd_e cmd;
    logic init;
    logic stalled;
    logic [ADDR_W-1:0] addr;
    logic ce_n;
    logic oe_n;
    logic rw_n;
    logic sem_n;
    logic [DATA_W-1:0] dout;
    logic doe_n;
    logic [DATA_W-1:0] rdata;
    logic rsp_valid;
    logic ready;
    logic init_done;
    logic hold_n;
    logic mail;
  } dpm_host_s;

  dpm_host_s s_r;
  dpm_host_s s_nxt;
  dpm_tmr_if tif ();
  logic busy_all_n;

  dpm_timer u_timer (
    .i_clock (i_clock),
    .i_rst (i_rst),
    .i_clk_en (i_clk_en),
    .tif (tif)
  );

  function automatic logic is_write(input dpm_cmd_e c);
    return (c == DPM_MEM_WR) || (c == DPM_SEM_REQ) || (c == DPM_SEM_REL) || (c == DPM_POST_MAIL);
  endfunction : is_write

  function automatic logic is_sem(input dpm_cmd_e c);
    return (c == DPM_SEM_REQ) || (c == DPM_SEM_REL) || (c == DPM_SEM_RD);
  endfunction : is_sem

  // Stacked devices share one word, so any low busy stalls a write access; reads ignore busy
  assign busy_all_n = &i_contention_flag_n;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rsp_valid = 1'b0;
    s_nxt.hold_n = ~i_block_writes;
    s_nxt.mail = ~i_mailbox_flag_n;
    tif.start = 1'b0;
    tif.load = TMR_W'(ACCESS_CYC);
    case (s_r.st)
      DPM_ST_INIT: begin
        // Flag has no power-up value; a read of our own mailbox word clears it
        s_nxt.cmd = DPM_TAKE_MAIL;
        s_nxt.init = 1'b1;
        s_nxt.stalled = 1'b0;
        s_nxt.addr = OWN_MBOX;
        s_nxt.ce_n = 1'b0;
        s_nxt.st = DPM_ST_SETUP;
      end
      DPM_ST_IDLE: begin
        if (i_cmd_valid) begin
          s_nxt.cmd = i_cmd;
          s_nxt.init = 1'b0;
          s_nxt.stalled = 1'b0;
          s_nxt.ready = 1'b0;
          s_nxt.st = DPM_ST_SETUP;
          case (i_cmd)
            DPM_POST_MAIL: s_nxt.addr = PEER_MBOX;
            DPM_TAKE_MAIL: s_nxt.addr = OWN_MBOX;
            DPM_SEM_REQ, DPM_SEM_REL, DPM_SEM_RD: s_nxt.addr = {9'h000, i_cmd_addr[SEM_SEL_W-1:0]};
            default: s_nxt.addr = i_cmd_addr;
          endcase
          if (is_sem(i_cmd)) begin
            s_nxt.sem_n = 1'b0;
            s_nxt.ce_n = 1'b1;
          end else begin
            s_nxt.ce_n = 1'b0;
          end
          if (i_cmd == DPM_SEM_REQ) begin
            s_nxt.dout = SEM_TAKE_DATA;
          end else if (i_cmd == DPM_SEM_REL) begin
            s_nxt.dout = SEM_FREE_DATA;
          end else begin
            s_nxt.dout = i_cmd_wdata;
          end
          s_nxt.doe_n = ~is_write(i_cmd);
        end
      end
      DPM_ST_SETUP: begin
        // Address and selects settle for one cycle before the strobe
        if (is_write(s_r.cmd)) begin
          s_nxt.rw_n = 1'b0;
        end else begin
          s_nxt.oe_n = 1'b0;
        end
        tif.start = 1'b1;
        s_nxt.st = DPM_ST_STROBE;
      end
      DPM_ST_STROBE: begin
        if (is_write(s_r.cmd) && !busy_all_n) begin
          // Device drops the write anyway; stall and repeat once busy clears
          s_nxt.rw_n = 1'b1;
          s_nxt.stalled = 1'b1;
          s_nxt.st = DPM_ST_WAITB;
        end else if (tif.done) begin
          s_nxt.rdata = i_data;
          s_nxt.rw_n = 1'b1;
          s_nxt.oe_n = 1'b1;
          s_nxt.st = DPM_ST_END;
        end
      end
      DPM_ST_WAITB: begin
        if (busy_all_n) begin
          s_nxt.st = DPM_ST_SETUP;
        end
      end
      DPM_ST_END: begin
        s_nxt.ce_n = 1'b1;
        s_nxt.sem_n = 1'b1;
        s_nxt.doe_n = 1'b1;
        s_nxt.ready = 1'b1;
        s_nxt.st = DPM_ST_IDLE;
        if (s_r.init) begin
          s_nxt.init_done = 1'b1;
        end else begin
          s_nxt.rsp_valid = 1'b1;
        end
      end
      default: begin
        s_nxt.st = DPM_ST_INIT;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '{st: DPM_ST_INIT, cmd: DPM_MEM_RD, init: 1'b0, stalled: 1'b0, addr: '0, ce_n: 1'b1,
               oe_n: 1'b1, rw_n: 1'b1, sem_n: 1'b1, dout: '0, doe_n: 1'b1, rdata: '0,
               rsp_valid: 1'b0, ready: 1'b0, init_done: 1'b0, hold_n: 1'b1, mail: 1'b0};
    end else if (i_clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign o_cmd_ready = s_r.ready;
  assign o_rsp_valid = s_r.rsp_valid;
  assign o_rsp_rdata = s_r.rdata;
  assign o_rsp_stalled = s_r.stalled;
  assign o_init_done = s_r.init_done;
  assign o_mail_pending = s_r.mail;
  assign o_addr = s_r.addr;
  assign o_ce_n = s_r.ce_n;
  assign o_oe_n = s_r.oe_n;
  assign o_rw_n = s_r.rw_n;
  assign o_token_space_select_n = s_r.sem_n;
  assign o_data = s_r.dout;
  assign o_data_oe_n = s_r.doe_n;
  assign o_contention_hold_n = s_r.hold_n;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst || !i_clk_en);

  sequence s_write_strobe;
    (s_r.st == DPM_ST_STROBE) && is_write(s_r.cmd);
  endsequence

  sequence s_busy_seen;
    s_write_strobe ##0 !busy_all_n;
  endsequence

  a_sem_ce_high: assert property (!o_token_space_select_n |-> o_ce_n)
    else $error("semaphore select low while memory select low");
  a_sem_write_data: assert property (!o_token_space_select_n && !o_rw_n |-> (o_data == SEM_TAKE_DATA) || (o_data == SEM_FREE_DATA))
    else $error("semaphore write data not uniform");
  a_ready_after_init: assert property (o_cmd_ready |-> o_init_done)
    else $error("command accepted before mailbox init");
  a_init_mbox_read: assert property ($rose(o_init_done) |-> $past(o_addr) == OWN_MBOX && $past(o_rw_n))
    else $error("init did not read own mailbox word");
  a_busy_stall: assert property (s_busy_seen |=> o_rw_n && o_rsp_stalled ##1 o_rw_n)
    else $error("write strobe kept during contention");
  a_busy_and: assert property (s_write_strobe ##0 (i_contention_flag_n != {NDEV{1'b1}}) |=> s_r.st == DPM_ST_WAITB)
    else $error("one busy low did not stall");
  a_hold_level: assert property (##1 o_contention_hold_n == !$past(i_block_writes))
    else $error("busy hold level wrong");
  a_no_fight: assert property (!o_oe_n |-> o_data_oe_n)
    else $error("data driven during read");
  a_mbox_addr: assert property (!o_rw_n && s_r.cmd == DPM_POST_MAIL |-> o_addr == PEER_MBOX && !o_ce_n)
    else $error("mail post to wrong word");
endmodule : dpm_host

//--- bench/dpm_dev_model.sv
`timescale 1ns/1ps
module dpm_dev_model (
  input wire logic [11:0] i_addr,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_rw_n,
  input wire logic i_sem_n,
  input wire logic [15:0] i_data,
  input wire logic i_block_n,
  input wire logic i_busy_n,
  input wire logic i_post,
  input wire logic [15:0] i_word,
  input wire logic i_psem,
  input wire logic [2:0] i_pidx,
  input wire logic i_pbit,
  input wire logic [11:0] i_paddr,
  input wire logic i_ptake,
  output logic [15:0] o_data,
  output logic o_busy_n,
  output logic o_flag_n,
  output logic o_pflag_n
);
  logic [15:0] mem [0:4095];
  logic [1:0] own [0:7];
  logic [7:0] pend = 8'h00;
  logic [15:0] sem_q = 16'hFFFF;
  logic [15:0] last = 16'h0000;
  logic [15:0] val;
  logic drv;
  logic match;
  initial begin
    for (int i = 0; i < 8; i++) own[i] = 2'h0;
    o_flag_n = 1'b0; // Power-up level is undefined; start asserted so the host must clear it
    o_pflag_n = 1'b1;
  end
  // Peer select on i_busy_n counts as settled first, so ties and near-ties always busy the host side
  assign match = !i_ce_n && !i_busy_n && (i_addr == i_paddr);
  // Peer side is never busied here, so both sides never show busy together
  assign o_busy_n = !match;
  assign drv = !i_oe_n && (!i_ce_n || !i_sem_n);
  assign val = !i_ce_n ? mem[i_addr] : sem_q;
  // Released bus shows the inverse, so a stale value never passes
  assign o_data = drv ? val : ~last;
  always @(val or drv) if (drv) last = val;
  always @(negedge (i_sem_n | i_oe_n)) sem_q = {16{own[i_addr[2:0]] != 2'h1}};
  task automatic sem_wr(input logic [1:0] me, input logic [2:0] k, input logic b);
    if (!b && own[k] == 2'h0) own[k] = me;
    else if (!b && own[k] != me) pend[k] = 1'b1;
    else if (b && own[k] == me) begin
      own[k] = pend[k] ? ~me : 2'h0;
      pend[k] = 1'b0;
    end
  endtask : sem_wr
  always @(posedge i_rw_n) begin
    if (!i_ce_n && o_busy_n && i_block_n) begin
      mem[i_addr] = i_data;
      if (i_addr == 12'hFFF) o_pflag_n = 1'b0;
    end
    if (i_ce_n && !i_sem_n) sem_wr(2'h1, i_addr[2:0], i_data[0]);
  end
  always @(posedge i_psem) sem_wr(2'h2, i_pidx, i_pbit);
  always @(posedge i_post) begin
    mem[12'hFFE] = i_word;
    o_flag_n = 1'b0;
  end
  always @(posedge i_ptake) o_pflag_n = 1'b1;
  always @(i_ce_n or i_oe_n or i_addr or o_busy_n)
    if (!i_ce_n && !i_oe_n && i_addr == 12'hFFE && o_busy_n) o_flag_n = 1'b1;
endmodule : dpm_dev_model

//--- bench/tb_dpm_host.sv
`timescale 1ns/1ps
module tb_dpm_host;
  import dpm_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic valid = 1'b0;
  dpm_cmd_e cmd = DPM_MEM_RD;
  logic [11:0] addr = 12'h000;
  logic [15:0] wdata = 16'h0000;
  logic blk = 1'b0;
  logic busy_n = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic ptake = 1'b0;
  logic post = 1'b0;
  logic [15:0] pword = 16'h0000;
  logic psem = 1'b0;
  logic [2:0] pidx = 3'h0;
  logic pbit = 1'b1;
  logic rdy, rv, stl, idone, mp, ce_n, oe_n, rw_n, sem_n, doe_n, hold_n, busy_o, flag_n, pflag_n;
  logic [15:0] rdata, dout, din, rd;
  logic [11:0] a_o;
  int error_cnt = 0;
  int tests_run = 0;
  dpm_host u_dpm_host (.i_clock(i_clock), .i_rst(i_rst), .i_clk_en(1'b1), .i_cmd_valid(valid), .i_cmd(cmd),
    .i_cmd_addr(addr), .i_cmd_wdata(wdata), .i_block_writes(blk), .o_cmd_ready(rdy), .o_rsp_valid(rv),
    .o_rsp_rdata(rdata), .o_rsp_stalled(stl), .o_init_done(idone), .o_mail_pending(mp), .o_addr(a_o),
    .o_ce_n(ce_n), .o_oe_n(oe_n), .o_rw_n(rw_n), .o_token_space_select_n(sem_n), .o_data(dout),
    .o_data_oe_n(doe_n), .i_data(din), .i_contention_flag_n(busy_o), .i_mailbox_flag_n(flag_n),
    .o_contention_hold_n(hold_n));
  // Undriven data bus shows the inverse, so a write whose data is not driven lands a wrong word
  dpm_dev_model u_dpm_dev_model (.i_addr(a_o), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_rw_n(rw_n), .i_sem_n(sem_n),
    .i_data(doe_n ? ~dout : dout), .i_block_n(hold_n), .i_busy_n(busy_n), .i_post(post), .i_word(pword),
    .i_psem(psem), .i_pidx(pidx), .i_pbit(pbit), .i_paddr(paddr), .i_ptake(ptake), .o_data(din),
    .o_busy_n(busy_o), .o_flag_n(flag_n), .o_pflag_n(pflag_n));
  initial forever #2 i_clock = ~i_clock;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk
  task automatic run(input dpm_cmd_e c, input logic [11:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 100) begin
      @(negedge i_clock);
      n++;
    end
    cmd = c;
    addr = a;
    wdata = d;
    valid = 1'b1;
    @(negedge i_clock);
    valid = 1'b0;
    n = 0;
    while (rv !== 1'b1 && n < 200) begin
      @(negedge i_clock);
      n++;
    end
    chk({15'h0, rv}, 16'h1, "no response");
    rd = rdata;
  endtask : run
  task automatic peer_sem(input logic [2:0] k, input logic b);
    pidx = k;
    pbit = b;
    psem = 1'b1;
    @(negedge i_clock);
    psem = 1'b0;
  endtask : peer_sem
  task automatic peer_post(input logic [15:0] w);
    pword = w;
    post = 1'b1;
    repeat (3) @(negedge i_clock);
    post = 1'b0;
  endtask : peer_post
  task automatic t_mail;
    peer_post(16'hA5C3);
    chk({15'h0, mp}, 16'h1, "mail not seen");
    run(DPM_TAKE_MAIL, LEFT_MBOX_ADDR, 16'h0000);
    chk(rd, 16'hA5C3, "mail word");
    chk({15'h0, flag_n}, 16'h1, "flag not cleared");
    run(DPM_POST_MAIL, RIGHT_MBOX_ADDR, 16'h3C5A);
    chk({15'h0, pflag_n}, 16'h0, "peer flag not set");
    chk(u_dpm_dev_model.mem[12'hFFF], 16'h3C5A, "posted word");
    ptake = 1'b1;
    @(negedge i_clock);
    ptake = 1'b0;
    chk({15'h0, pflag_n}, 16'h1, "peer flag not cleared");
    peer_post(16'h1111);
    paddr = LEFT_MBOX_ADDR;
    busy_n = 1'b0;
    run(DPM_TAKE_MAIL, LEFT_MBOX_ADDR, 16'h0000);
    chk({15'h0, flag_n}, 16'h0, "flag cleared under busy");
    busy_n = 1'b1;
    $display("done t_mail");
  endtask : t_mail
  task automatic t_mem;
    run(DPM_MEM_WR, 12'h123, 16'hBEEF);
    run(DPM_MEM_RD, 12'h123, 16'h0000);
    chk(rd, 16'hBEEF, "read back");
    paddr = 12'h124;
    busy_n = 1'b0;
    run(DPM_MEM_WR, 12'h125, 16'h2468);
    chk({15'h0, stl}, 16'h0, "stall without address match");
    chk(u_dpm_dev_model.mem[12'h125], 16'h2468, "unmatched write lost");
    fork
      run(DPM_MEM_WR, 12'h124, 16'h1357);
      begin
        repeat (30) @(negedge i_clock);
        chk({15'h0, stl}, 16'h1, "stall not shown");
        chk({15'h0, rv}, 16'h0, "done while busy");
        busy_n = 1'b1;
      end
    join
    chk(u_dpm_dev_model.mem[12'h124], 16'h1357, "retry lost");
    blk = 1'b1;
    run(DPM_MEM_WR, 12'h123, 16'h0F0F);
    chk(u_dpm_dev_model.mem[12'h123], 16'hBEEF, "blocked write landed");
    blk = 1'b0;
    $display("done t_mem");
  endtask : t_mem
  task automatic t_sem;
    peer_sem(3'h5, 1'b0);
    run(DPM_SEM_REQ, 12'h005, SEM_TAKE_DATA);
    run(DPM_SEM_RD, 12'h005, 16'h0000);
    chk(rd, 16'hFFFF, "took held token");
    peer_sem(3'h5, 1'b1);
    run(DPM_SEM_RD, 12'h005, 16'h0000);
    chk(rd, 16'h0000, "token not passed");
    run(DPM_SEM_REL, 12'h005, SEM_FREE_DATA);
    run(DPM_SEM_RD, 12'h005, 16'h0000);
    chk(rd, 16'hFFFF, "token not freed");
    run(DPM_SEM_REQ, 12'hFFA, SEM_TAKE_DATA);
    run(DPM_SEM_RD, 12'h002, 16'h0000);
    chk(rd, 16'h0000, "index decode");
    $display("done t_sem");
  endtask : t_sem
  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  initial begin
    #40000;
    error_cnt++;
    test_done;
  end
  initial begin
    repeat (5) @(posedge i_clock);
    @(negedge i_clock);
    i_rst = 1'b0;
    repeat (40) @(negedge i_clock);
    chk({15'h0, idone}, 16'h1, "init not done");
    chk({15'h0, flag_n}, 16'h1, "init clear");
    $display("done t_init");
    t_mail;
    t_mem;
    t_sem;
    test_done;
  end
endmodule : tb_dpm_host
